// ### bench/cid_decoder_props.sv
`timescale 1ns/1ps
module cid_decoder_props
    import cid_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic code_ready,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wr_data,
    input wire logic [7:0] sfr_rd_data,
    input wire logic [1:0] op_len,
    input wire logic dec_valid,
    input wire cid_decode_type dec,
    input wire logic clock_halving_select,
    input wire logic int_tick,
    input wire logic mcycle_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [3:0] gap_q;
    logic seen_q;
    logic hs_q;
    // The gap counts every cycle; it is checked only after a tick under a steady halving bit.
    always_ff @(posedge ref_clk) begin
        gap_q <= mcycle_tick ? 4'h0 : gap_q + 4'h1;
        hs_q <= clock_halving_select;
        seen_q <= (rst || clock_halving_select != hs_q) ? 1'b0 : (seen_q || mcycle_tick);
    end
    chk_valid_pulse: assert property (dec_valid |=> !dec_valid)
        else $error("decode valid lasted more than one cycle");
    chk_emit_gap: assert property (dec_valid |-> code_ready && !$past(code_ready))
        else $error("result not preceded by one refused cycle");
    chk_dec_hold: assert property (!dec_valid && !$past(rst) |-> $stable(dec))
        else $error("decode output changed without valid");
    chk_len_match: assert property (dec_valid |-> dec.length == op_len && op_len != 2'h0)
        else $error("length output disagrees with result");
    chk_mcycle_len: assert property (mcycle_tick && seen_q && clock_halving_select == hs_q
        |-> gap_q == (clock_halving_select ? 4'hB : 4'h5))
        else $error("machine cycle length wrong");
    chk_mcycle_late: assert property (!mcycle_tick && seen_q && clock_halving_select == hs_q
        |-> gap_q < (clock_halving_select ? 4'hB : 4'h5))
        else $error("machine cycle tick missing");
    chk_int_full: assert property (!clock_halving_select |-> int_tick)
        else $error("internal clock not at full rate");
    chk_int_half: assert property (clock_halving_select && $past(clock_halving_select)
        |-> int_tick != $past(int_tick))
        else $error("internal clock not halved");
    chk_halve_write: assert property (sfr_wr_en && sfr_addr == 8'hA6
        |=> clock_halving_select == $past(sfr_wr_data[7]))
        else $error("halving bit not written");
    chk_wr_ignored: assert property (sfr_wr_en && sfr_addr != 8'hA6 |=> $stable(clock_halving_select))
        else $error("foreign write changed halving bit");
    chk_rd_data: assert property (sfr_rd_en |=> sfr_rd_data ==
        (($past(sfr_addr) == 8'hA6) ? {$past(clock_halving_select), 7'h00} : 8'h00))
        else $error("register read data wrong");
    chk_rd_hold: assert property (!sfr_rd_en && !rst |=> $stable(sfr_rd_data))
        else $error("read data changed without a read");
endmodule
bind cid_decoder cid_decoder_props u_props (.ref_clk, .rst, .code_ready, .sfr_wr_en, .sfr_rd_en, .sfr_addr,
    .sfr_wr_data, .sfr_rd_data, .op_len, .dec_valid, .dec, .clock_halving_select, .int_tick, .mcycle_tick);

// ### bench/cid_progmem.sv
`timescale 1ns/1ps
module cid_progmem (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic code_ready,
    input wire logic stall,
    output logic code_valid,
    output logic [7:0] code_byte,
    output logic [15:0] code_addr
);
    logic [7:0] q[$];
    logic [15:0] pc;
    logic rdy_s;
    logic nv;
    // Ready is combinational; sample it mid-cycle.
    always @(negedge ref_clk) rdy_s = code_ready;
    // Bytes are held until taken; idle data is inverted so stale bytes never match.
    always @(posedge ref_clk) begin
        if (rst) begin
            q.delete();
            code_valid <= 1'b0;
        end else begin
            if (code_valid && rdy_s) begin
                void'(q.pop_front());
                pc = pc + 16'h0001;
            end
            nv = q.size() > 0 && (!stall || (code_valid && !rdy_s));
            code_valid <= nv;
            code_byte <= nv ? q[0] : ~code_byte;
            code_addr <= nv ? pc : ~code_addr;
        end
    end
    // Quiet bus at time zero.
    initial begin
        code_valid = 1'b0;
        code_byte = 8'h00;
        code_addr = 16'h0000;
        pc = 16'h0000;
    end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
    import cid_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic stall = 1'b0;
    logic sfr_wr_en = 1'b0;
    logic sfr_rd_en = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wr_data = 8'h00;
    logic [1:0] reg_bank = 2'h0;
    logic code_valid, code_ready, dec_valid, clock_halving_select, int_tick, mcycle_tick;
    logic [7:0] code_byte, sfr_rd_data;
    logic [15:0] code_addr;
    logic [1:0] op_len;
    cid_decode_type dec;
    logic [41:0] exp_q[$];
    int n_fail = 0;
    int samples_checked = 0;
    logic a;
    cid_progmem pm (.ref_clk, .rst, .code_ready, .stall, .code_valid, .code_byte, .code_addr);
    cid_decoder dut (.ref_clk, .rst, .code_valid, .code_byte, .code_addr, .code_ready, .reg_bank, .sfr_wr_en,
        .sfr_rd_en, .sfr_addr, .sfr_wr_data, .sfr_rd_data, .op_len, .dec_valid, .dec, .clock_halving_select,
        .int_tick, .mcycle_tick);
    // 40 MHz clock; the far side stalls about one cycle in four.
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) #1 stall = ($urandom_range(3) == 0);
    task automatic chk(logic [15:0] seen, logic [15:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            n_fail++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Lengths per low nibble, one hex digit per high nibble with F leftmost.
    function automatic int len_of(logic [7:0] op);
        logic [63:0] t;
        case (op[3:0])
            4'h0: t = 64'h1122_2232_2222_3331;
            4'h1: t = 64'h2222_2222_2222_2222;
            4'h2: t = 64'h1122_2222_2222_1133;
            4'h3: t = 64'h1111_1111_1333_1111;
            4'h4: t = 64'h1111_3121_2222_2211;
            4'h5: t = 64'h2232_3123_3222_2222;
            4'h6, 4'h7: t = 64'h1111_3212_2111_1111;
            default: t = 64'h1121_3212_2111_1111;
        endcase
        return int'(t[op[7:4]*4 +: 4]);
    endfunction
    // Every result is compared with the expectation queued when its bytes were offered.
    task automatic check_one();
        logic [15:0] pc, npc, tg;
        logic [7:0] op, b2, b3;
        logic [1:0] bk;
        int len;
        cid_branch_type br;
        if (exp_q.size() == 0) begin
            chk(16'h0001, 16'h0000);
            return;
        end
        {pc, op, b2, b3, bk} = exp_q.pop_front();
        len = len_of(op);
        npc = pc + 16'(len);
        br = cid_br_none;
        tg = npc;
        if (op == 8'h02 || op == 8'h12) begin
            br = cid_br_long;
            tg = {b2, b3};
        end else if (op[3:0] == 4'h1) begin
            br = cid_br_abs;
            tg = {npc[15:11], op[7:5], b2};
        end else if (op inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h80} || op[7:3] == 5'h1B) begin
            br = cid_br_rel;
            tg = npc + {{8{b2[7]}}, b2};
        end else if (op inside {8'h10, 8'h20, 8'h30, 8'hD5} || (op[7:4] == 4'hB && op[3:0] > 4'h3)) begin
            br = cid_br_rel;
            tg = npc + {{8{b3[7]}}, b3};
        end else if (op == 8'h73)
            br = cid_br_acc_dptr;
        else if (op == 8'h22 || op == 8'h32)
            br = cid_br_return;
        chk(dec.opcode, op);
        chk(dec.length, 16'(len));
        chk(op_len, 16'(len));
        chk(dec.branch, br);
        if (br < cid_br_acc_dptr) chk(dec.target, tg);
        if (op[3]) chk({dec.mode, dec.work_reg}, {cid_mode_reg, bk, op[2:0]});
        if (op[3:1] == 3'h3 || (op[7:5] == 3'h7 && op[3:1] == 3'h1))
            chk({dec.mode, dec.work_reg}, {cid_mode_ind, bk, 2'h0, op[0]});
        if (op[7:5] == 3'h7 && op[3:0] inside {4'h0, 4'h2, 4'h3})
            chk({dec.space, dec.extended_internal_ram_write, dec.extended_internal_ram_wide}, {cid_space_extended_internal_ram, op[4], op[3:0] == 4'h0});
        if (op == 8'h83 || op == 8'h93) chk(dec.space, cid_space_code);
        if (op inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC4}) chk(dec.acc_unary, 1'b1);
        chk(dec.nibble_xchg, op[7:1] == 7'h6B);
        case (op)
            8'h90: chk(dec.imm16, {b2, b3});
            8'h74: chk({dec.has_imm, dec.imm8}, {1'b1, b2});
            8'h75: chk({dec.has_imm, dec.imm8}, {1'b1, b3});
            8'h85: chk({dec.dir_src, dec.dir_addr}, {b2, b3});
            8'hE5: chk({dec.dir_is_sfr, dec.dir_addr}, {b2[7], b2});
            8'hC2, 8'hD2: chk({dec.bit_is_sfr, dec.bit_byte}, {b2[7], b2[7] ? b2 & 8'hF8 : 8'h20 + b2[6:3]});
            default: ;
        endcase
    endtask
    always @(negedge ref_clk) if (dec_valid === 1'b1) check_one();
    task automatic send(logic [7:0] op, logic [15:0] pc);
        logic [7:0] b2, b3;
        b2 = 8'($urandom);
        b3 = 8'($urandom);
        exp_q.push_back({pc, op, b2, b3, reg_bank});
        pm.q.push_back(op);
        if (len_of(op) > 1) pm.q.push_back(b2);
        if (len_of(op) > 2) pm.q.push_back(b3);
    endtask
    // A write, or with w low a read whose data is checked against d.
    task automatic wr(logic [7:0] ad, logic [7:0] d, logic w = 1'b1);
        @(posedge ref_clk);
        #1 {sfr_wr_en, sfr_rd_en} = {w, !w};
        sfr_addr = ad;
        sfr_wr_data = d;
        @(posedge ref_clk);
        #1 {sfr_wr_en, sfr_rd_en} = 2'b00;
        if (!w) chk(sfr_rd_data, d);
    endtask
    // Finds a machine cycle tick, then counts the cycles to the next one.
    task automatic per(int e);
        int k;
        for (int j = 0; j < 2; j++) begin
            k = 0;
            do begin
                @(negedge ref_clk);
                k++;
            end while (mcycle_tick !== 1'b1 && k < 40);
        end
        chk(16'(k), 16'(e));
    endtask
    // Watchdog, well above the test length.
    initial begin
        #1000000;
        n_fail++;
        end_of_test();
    end
    initial begin
        int k;
        void'($urandom(99));
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        wr(8'hA6, 8'h00, 0);
        wr(8'hA5, 8'h00, 0);
        wr(8'hA6, 8'h80);
        chk(clock_halving_select, 1'b1);
        wr(8'hA6, 8'h80, 0);
        @(negedge ref_clk);
        a = int_tick;
        @(negedge ref_clk);
        chk(int_tick, !a);
        per(12);
        wr(8'hA5, 8'h00);
        chk(clock_halving_select, 1'b1);
        wr(8'hA6, 8'h00);
        per(6);
        chk(int_tick, 1'b1);
        $display("test clock_control done");
        // Each opcode is followed back to back by a random one, so the second is refused once.
        for (int i = 0; i < 256; i++) begin
            @(posedge ref_clk);
            #1 reg_bank = 2'($urandom);
            pm.pc = 16'($urandom);
            send(i[7:0], pm.pc);
            send(8'($urandom), pm.pc + 16'(len_of(i[7:0])));
            k = 0;
            while ((exp_q.size() > 0 || pm.q.size() > 0) && k < 80) begin
                @(posedge ref_clk);
                k++;
            end
            if (k >= 80) chk(16'(k), 16'h0000);
        end
        $display("test opcode_sweep done");
        wr(8'hA6, 8'h80);
        @(posedge ref_clk);
        #1 rst = 1'b1;
        @(posedge ref_clk);
        #1 rst = 1'b0;
        wr(8'hA6, 8'h00, 0);
        $display("test mid_reset done");
        end_of_test();
    end
endmodule

// ### src/cid_clkctl.sv
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_clkctl
    import cid_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wr_data,
    output logic [7:0] sfr_rd_data,
    output logic clock_halving_select,
    output logic int_tick,
    output logic mcycle_tick
);
    logic halve_q;
    logic [7:0] rd_q;
    logic phase_q;
    logic [3:0] osc_cnt_q;
    wire hit = (sfr_addr == `CID_CLK_CTRL_ADDR);
    wire [3:0] mcyc_len = halve_q ? `CID_MCYC_OSC_HALVED : `CID_MCYC_OSC_FULL;
    wire mcyc_wrap = (osc_cnt_q >= mcyc_len - 4'd1);
    // Only the halving bit is kept; the reserved low bits are expected as zero and dropped.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            halve_q <= 1'b0;
        end else if (sfr_wr_en && hit) begin
            halve_q <= sfr_wr_data[`CID_HALVE_BIT];
        end
    end
    // Read data is registered; the watchdog bit is not part of this block and reads zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_q <= `CID_CLK_CTRL_RESET;
        end else if (sfr_rd_en) begin
            rd_q <= hit ? {halve_q, 7'h00} : 8'h00;
        end
    end
    // Oscillator period counter; a machine-cycle change takes effect at the next wrap or below the new limit.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= 1'b0;
            osc_cnt_q <= 4'h0;
        end else begin
            phase_q <= halve_q ? ~phase_q : 1'b0;
            osc_cnt_q <= mcyc_wrap ? 4'h0 : osc_cnt_q + 4'd1;
        end
    end
    assign sfr_rd_data = rd_q;
    assign clock_halving_select = halve_q;
    assign int_tick = ~halve_q | phase_q;
    assign mcycle_tick = mcyc_wrap;
endmodule

// ### src/cid_decoder.sv
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_decoder
    import cid_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic code_valid,
    input wire logic [7:0] code_byte,
    input wire logic [15:0] code_addr,
    output logic code_ready,
    input wire logic [1:0] reg_bank,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wr_data,
    output logic [7:0] sfr_rd_data,
    output logic [1:0] op_len,
    output logic dec_valid,
    output cid_decode_type dec,
    output logic clock_halving_select,
    output logic int_tick,
    output logic mcycle_tick
);
    typedef enum logic [1:0] {
        cid_st_opcode,
        cid_st_byte2,
        cid_st_byte3,
        cid_st_emit
    } cid_state_type;

    // Instruction length from the opcode byte alone, following the standard opcode map.
    function automatic logic [1:0] op_length(input logic [7:0] op);
        logic [3:0] row;
        logic [3:0] col;
        row = op[7:4];
        col = op[3:0];
        op_length = 2'd1;
        if (op[3] || col == 4'h6 || col == 4'h7) begin
            // Register and indirect columns: immediate or direct companions add bytes.
            if (row == 4'h7 || row == 4'h8 || row == 4'hA) begin
                op_length = 2'd2;
            end else if (row == 4'hB) begin
                op_length = 2'd3;
            end else if (row == 4'hD && op[3]) begin
                op_length = 2'd2;
            end else begin
                op_length = 2'd1;
            end
        end else begin
            case (col)
                4'h0: begin
                    if (row == 4'h0 || row == 4'hE || row == 4'hF) begin
                        op_length = 2'd1;
                    end else if (row <= 4'h3 || row == 4'h9) begin
                        op_length = 2'd3;
                    end else begin
                        op_length = 2'd2;
                    end
                end
                4'h1: begin
                    op_length = 2'd2;
                end
                4'h2: begin
                    if (row <= 4'h1) begin
                        op_length = 2'd3;
                    end else if (row <= 4'h3 || row >= 4'hE) begin
                        op_length = 2'd1;
                    end else begin
                        op_length = 2'd2;
                    end
                end
                4'h3: begin
                    op_length = (row >= 4'h4 && row <= 4'h6) ? 2'd3 : 2'd1;
                end
                4'h4: begin
                    case (row)
                        4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: begin
                            op_length = 2'd1;
                        end
                        4'hB: begin
                            op_length = 2'd3;
                        end
                        default: begin
                            op_length = 2'd2;
                        end
                    endcase
                end
                4'h5: begin
                    case (row)
                        4'h7, 4'h8, 4'hB, 4'hD: begin
                            op_length = 2'd3;
                        end
                        4'hA: begin
                            op_length = 2'd1;
                        end
                        default: begin
                            op_length = 2'd2;
                        end
                    endcase
                end
                default: begin
                    op_length = 2'd1;
                end
            endcase
        end
    endfunction

    // Byte holding a bit: low bits sit in the RAM flag area, high bits in bit-addressable registers.
    function automatic logic [7:0] bit_home(input logic [7:0] bit_addr);
        bit_home = bit_addr[7] ? {bit_addr[7:3], 3'b000} : (`CID_BIT_RAM_BASE + {4'h0, bit_addr[6:3]});
    endfunction

    cid_state_type state_q;
    cid_state_type state_d;
    logic [7:0] opc_q;
    logic [7:0] b2_q;
    logic [7:0] b3_q;
    logic [15:0] pc_q;
    logic [1:0] len_q;
    logic [1:0] bank_q;
    logic dec_valid_q;
    cid_decode_type dec_q;
    cid_decode_type dec_d;
    cid_branch_type branch_w;
    logic [15:0] target_w;

    // A byte is taken whenever the fetch side offers one and the decoder is collecting.
    wire take = code_valid && (state_q != cid_st_emit);
    wire [1:0] first_len = op_length(code_byte);

    // Collection sequence: opcode, then as many operand bytes as the length demands.
    always_comb begin
        state_d = state_q;
        case (state_q)
            cid_st_opcode: begin
                if (take) begin
                    state_d = (first_len == 2'd1) ? cid_st_emit : cid_st_byte2;
                end
            end
            cid_st_byte2: begin
                if (take) begin
                    state_d = (len_q == 2'd3) ? cid_st_byte3 : cid_st_emit;
                end
            end
            cid_st_byte3: begin
                if (take) begin
                    state_d = cid_st_emit;
                end
            end
            default: begin
                state_d = cid_st_opcode;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= cid_st_opcode;
        end else begin
            state_q <= state_d;
        end
    end

    // Instruction bytes; bytes not used by a shorter instruction read as zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opc_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            pc_q <= 16'h0000;
            len_q <= 2'd1;
            bank_q <= 2'd0;
        end else if (take && state_q == cid_st_opcode) begin
            opc_q <= code_byte;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            pc_q <= code_addr;
            len_q <= first_len;
            bank_q <= reg_bank;
        end else if (take && state_q == cid_st_byte2) begin
            b2_q <= code_byte;
        end else if (take && state_q == cid_st_byte3) begin
            b3_q <= code_byte;
        end
    end

    cid_target u_target (
        .opcode(opc_q),
        .pc(pc_q),
        .length(len_q),
        .byte2(b2_q),
        .byte3(b3_q),
        .branch(branch_w),
        .target(target_w)
    );

    // Operand classification from the latched opcode.
    wire [3:0] row = opc_q[7:4];
    wire [3:0] col = opc_q[3:0];
    wire is_movx = (row >= 4'hE) && (col == 4'h0 || col == 4'h2 || col == 4'h3);
    wire is_rn = opc_q[3];
    wire is_ri = (col == 4'h6 || col == 4'h7) || (is_movx && col != 4'h0);
    wire is_dir_imm_op = (opc_q == 8'h43) || (opc_q == 8'h53) || (opc_q == 8'h63) || (opc_q == 8'h75);
    wire is_bit = (opc_q == 8'h10) || (opc_q == 8'h20) || (opc_q == 8'h30) || (opc_q == 8'hA0) ||
                  (opc_q == 8'hB0) || (col == 4'h2 && row >= 4'h7 && row <= 4'hD);
    wire is_dir = (col == 4'h5 && row != 4'hA) || (col == 4'h2 && row >= 4'h4 && row <= 4'h6) ||
                  (col == 4'h3 && row >= 4'h4 && row <= 4'h6) || (opc_q == 8'hC0) || (opc_q == 8'hD0) ||
                  ((is_rn || col == 4'h6 || col == 4'h7) && (row == 4'h8 || row == 4'hA));
    wire is_imm = (col == 4'h4 && len_q != 2'd1) || is_dir_imm_op || (opc_q == 8'h90) ||
                  ((is_rn || col == 4'h6 || col == 4'h7) && (row == 4'h7 || row == 4'hB));
    wire [4:0] rn_addr = {bank_q, opc_q[2:0]};
    wire [4:0] ri_addr = {bank_q, 2'b00, opc_q[0]};
    wire [7:0] dir_dest = (opc_q == 8'h85) ? b3_q : b2_q;
    wire [7:0] bit_sel = (is_bit) ? b2_q : 8'h00;

    // Assemble the record that goes out with the completed instruction.
    always_comb begin
        dec_d = '0;
        dec_d.opcode = opc_q;
        dec_d.length = len_q;
        dec_d.mode = is_rn ? cid_mode_reg : is_ri ? cid_mode_ind : is_bit ? cid_mode_bit :
                     is_dir ? cid_mode_dir : is_imm ? cid_mode_imm : cid_mode_none;
        dec_d.work_reg = is_rn ? rn_addr : is_ri ? ri_addr : 5'h00;
        dec_d.has_dir = is_dir;
        dec_d.dir_addr = is_dir ? dir_dest : 8'h00;
        dec_d.dir_src = is_dir ? b2_q : 8'h00;
        dec_d.dir_is_sfr = is_dir && (dir_dest >= `CID_SFR_BASE);
        dec_d.has_bit = is_bit;
        dec_d.bit_addr = bit_sel;
        dec_d.bit_byte = is_bit ? bit_home(bit_sel) : 8'h00;
        dec_d.bit_is_sfr = is_bit && bit_sel[7];
        dec_d.has_imm = is_imm;
        dec_d.imm8 = is_imm ? (is_dir_imm_op ? b3_q : b2_q) : 8'h00;
        dec_d.imm16 = (opc_q == 8'h90) ? {b2_q, b3_q} : 16'h0000;
        dec_d.branch = branch_w;
        dec_d.target = target_w;
        dec_d.space = is_movx ? cid_space_extended_internal_ram :
                      (opc_q == 8'h83 || opc_q == 8'h93) ? cid_space_code : cid_space_internal;
        dec_d.extended_internal_ram_write = is_movx && row == 4'hF;
        dec_d.extended_internal_ram_wide = is_movx && col == 4'h0;
        dec_d.acc_unary = (opc_q == 8'hE4) || (opc_q == 8'hF4) || (opc_q == 8'hC4) ||
                          (col == 4'h3 && row <= 4'h3);
        dec_d.nibble_xchg = (opc_q == 8'hD6) || (opc_q == 8'hD7);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dec_q <= '0;
            dec_valid_q <= 1'b0;
        end else begin
            dec_valid_q <= (state_q == cid_st_emit);
            if (state_q == cid_st_emit) begin
                dec_q <= dec_d;
            end
        end
    end

    cid_clkctl u_clkctl (
        .ref_clk(ref_clk),
        .rst(rst),
        .sfr_wr_en(sfr_wr_en),
        .sfr_rd_en(sfr_rd_en),
        .sfr_addr(sfr_addr),
        .sfr_wr_data(sfr_wr_data),
        .sfr_rd_data(sfr_rd_data),
        .clock_halving_select(clock_halving_select),
        .int_tick(int_tick),
        .mcycle_tick(mcycle_tick)
    );

    // The emit cycle refuses bytes so the record can be registered without a buffer.
    assign code_ready = (state_q != cid_st_emit);
    assign op_len = len_q;
    assign dec_valid = dec_valid_q;
    assign dec = dec_q;
endmodule

// ### src/cid_pkg.sv
package cid_pkg;
    // Addressing form of the principal operand.
    typedef enum logic [2:0] {
        cid_mode_none,
        cid_mode_reg,
        cid_mode_ind,
        cid_mode_bit,
        cid_mode_dir,
        cid_mode_imm
    } cid_mode_type;
    // How the next program counter is formed.
    typedef enum logic [2:0] {
        cid_br_none,
        cid_br_long,
        cid_br_abs,
        cid_br_rel,
        cid_br_acc_dptr,
        cid_br_return
    } cid_branch_type;
    // Memory space reached by the data access.
    typedef enum logic [1:0] {
        cid_space_internal,
        cid_space_extended_internal_ram,
        cid_space_code
    } cid_space_type;
    typedef struct packed {
        logic [7:0] opcode;
        logic [1:0] length;
        cid_mode_type mode;
        logic [4:0] work_reg;
        logic has_dir;
        logic [7:0] dir_addr;
        logic [7:0] dir_src;
        logic dir_is_sfr;
        logic has_bit;
        logic [7:0] bit_addr;
        logic [7:0] bit_byte;
        logic bit_is_sfr;
        logic has_imm;
        logic [7:0] imm8;
        logic [15:0] imm16;
        cid_branch_type branch;
        logic [15:0] target;
        cid_space_type space;
        logic extended_internal_ram_write;
        logic extended_internal_ram_wide;
        logic acc_unary;
        logic nibble_xchg;
    } cid_decode_type;
endpackage

// ### src/cid_regs.svh
`ifndef CID_REGS_SVH
`define CID_REGS_SVH
// Summary of operation
// - Decode the standard 8-bit controller instruction set, except that external-data moves go to on-chip extended RAM.
// - Register forms pick working register zero to seven in the active bank.
// - Direct operands reach low 128 RAM bytes and all special function registers.
// - Indirect RAM operands take their address from register zero or one only.
// - Immediate byte is in the instruction; a 16-bit immediate uses bytes two and three.
// - Bit operands reach 128 RAM flags and bits of bit-addressable function registers.
// - External-data moves go to the on-chip extended RAM, not an external bus.
// - Long call and long jump carry a full 16-bit target.
// - Absolute call and jump combine 11 bits with the next address page of 2 Kbyte.
// - Short and conditional jumps add a signed byte to the next instruction address.
// - Add, add-with-carry, subtract: one byte for register/indirect, two for direct/immediate.
// - Logic ops on a direct byte: three bytes with immediate, two with accumulator.
// - Accumulator clear, complement, rotates and nibble swap are single-byte.
// - Direct-from-direct or immediate moves are three bytes; immediate to register two.
// - Loading the data pointer is three bytes, constant in bytes two and three.
// - Code-byte moves read accumulator plus pointer or counter, one byte long.
// - External-data moves are one byte, 8-bit or 16-bit address, both directions.
// - Push and pop of a direct byte are two bytes each.
// - Exchanges swap accumulator with register, direct or indirect; one swaps low nibbles.
// - Machine cycle is 12 oscillator periods with halving set, six when clear.
// - Halving set runs the internal clock at half the oscillator, clear at full rate.
`define CID_CLK_CTRL_ADDR 8'hA6
`define CID_CLK_CTRL_RESET 8'h00
`define CID_HALVE_BIT 7
`define CID_MCYC_OSC_HALVED 4'd12
`define CID_MCYC_OSC_FULL 4'd6
`define CID_SFR_BASE 8'h80
`define CID_BIT_RAM_BASE 8'h20
`endif

// ### src/cid_target.sv
`timescale 1ns/1ps
module cid_target
    import cid_pkg::*;
(
    input wire logic [7:0] opcode,
    input wire logic [15:0] pc,
    input wire logic [1:0] length,
    input wire logic [7:0] byte2,
    input wire logic [7:0] byte3,
    output cid_branch_type branch,
    output logic [15:0] target
);
    wire [15:0] next_pc = pc + {14'h0000, length};
    wire is_long = (opcode == 8'h02) || (opcode == 8'h12);
    wire is_abs = (opcode[4:0] == 5'h01) || (opcode[4:0] == 5'h11);
    wire rel_last = (opcode == 8'h10) || (opcode == 8'h20) || (opcode == 8'h30) ||
                    (opcode[7:4] == 4'hB && (opcode[3] || opcode[3:1] == 3'b011 || opcode[3:0] == 4'h4
                     || opcode[3:0] == 4'h5)) || (opcode == 8'hD5);
    wire rel_mid = (opcode[3:0] == 4'h0 && opcode[7:4] >= 4'h4 && opcode[7:4] <= 4'h8) ||
                   (opcode[7:3] == 5'b11011);
    wire [7:0] offset = rel_last ? byte3 : byte2;
    // Relative offsets count from the first byte of the following instruction.
    wire [15:0] rel_pc = next_pc + {{8{offset[7]}}, offset};
    assign branch = is_long ? cid_br_long : is_abs ? cid_br_abs : (rel_last || rel_mid) ? cid_br_rel :
                    (opcode == 8'h73) ? cid_br_acc_dptr :
                    (opcode == 8'h22 || opcode == 8'h32) ? cid_br_return : cid_br_none;
    // The absolute form keeps the 2 Kbyte page of the next instruction.
    assign target = is_long ? {byte2, byte3} :
                    is_abs ? {next_pc[15:11], opcode[7:5], byte2} :
                    (rel_last || rel_mid) ? rel_pc : next_pc;
endmodule
